// *** design/load_switch_pkg.sv ***
package load_switch_pkg;
    // switch indices
    localparam int SW_LOW = 0;
    localparam int SW_FIVE = 1;
    localparam int SW_HIGH = 2;
    localparam int NUM_SWITCHES = 3;
    localparam int NUM_RAILS = 5;

    // positions of the analog flags in the synchronizer vector
    localparam int FLG_CORE_GOOD = 0;
    localparam int FLG_IO_GOOD = 1;
    localparam int FLG_SYS_LOW = 2;
    localparam int FLG_UV_LOW = 3;
    localparam int FLG_UV_HYS_LOW = 4;
    localparam int FLG_PFAIL = 5;
    localparam int FLG_BIAS_LOW = 6;
    localparam int FLG_COIN_HI = 7;
    localparam int FLG_MAIN_HI = 8;
    localparam int FLG_FAST_SLEW = 9;
    localparam int FLG_FIVE_IN_LOW = 10;
    localparam int FLG_LIMIT = 11;
    localparam int FLG_OTEMP = 14;
    localparam int NUM_FLAGS = 17;

    // power-manager state codes presented by the sequencer
    localparam logic [2:0] PMIC_OFF = 3'h0;
    localparam logic [2:0] PMIC_AWAIT = 3'h1;
    localparam logic [2:0] PMIC_ACTIVE = 3'h2;
    localparam logic [2:0] PMIC_SUSPEND = 3'h3;
    localparam logic [2:0] PMIC_RECOVERY = 3'h4;

    // reset values
    localparam logic [2:0] SWITCH_ON_RESET = 3'h0;
    localparam logic [1:0] LIMIT_RESET = 2'h0;

    // input dip persistence before undervoltage shutdown
    localparam int CLK_MHZ = 100;
    localparam int UV_DIP_TIME_US = 5000;
    localparam int UV_DIP_CYCLES = UV_DIP_TIME_US * CLK_MHZ;
    localparam int UV_CNT_W = 20;

    typedef enum logic [0:0] {
        PATH_MAIN = 1'b0,
        PATH_COIN = 1'b1
    } path_t;
endpackage

// *** design/load_switch_powerfail_ctrl.sv ***
// Contract
// - backup power good is high only while both backup bucks regulate
// - backup rail faults never start power-down, disable rails or touch main good
// - system supply under 2.5 V resets core, kills rails, discharges converters and LDO
// - each load switch follows its own enable bit
// - low-voltage switch obeys sequencer and host; others obey host only
// - discharge enable, default off, grounds a disabled switch output
// - power-fail trip disables each switch whose shed bit is set
// - a shed switch stays off until host re-enables it; a sequencer on also re-enables the low-voltage switch here
// - current limiting raises overcurrent interrupt while switch stays on
// - local overtemperature forces switch off, holds fault bit, recovers itself
// - two-bit field picks five-volt limit; overcurrent reported by interrupt
// - five-volt input under 2.7 V forces switch off and sets fault
// - two-bit field picks one of four high-voltage switch limits
// - undervoltage dip shuts down only after 5 ms; recovery level follows slew
// - power-fail trip starts power-down only when shutdown enable is one
// - power-fail comparator has no interrupt or status bit
// - powered-up states always select the main backup input
// - off state picks the higher input with 150 mV hysteresis
// - bias below internal regulator forces off state and main backup input
`timescale 1ns/1ps
module load_switch_powerfail_ctrl #(
    parameter int UV_DIP_LIMIT = load_switch_pkg::UV_DIP_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_core_buck_good,
    input wire logic i_io_buck_good,
    input wire logic i_sys_below_min,
    input wire logic i_uv_below,
    input wire logic i_uv_below_hys,
    input wire logic i_powerfail_sense_input,
    input wire logic i_bias_below_regulator,
    input wire logic i_coin_cell_higher,
    input wire logic i_main_backup_higher,
    input wire logic i_fast_slew,
    input wire logic i_five_volt_in_low,
    input wire logic [load_switch_pkg::NUM_SWITCHES-1:0] i_switch_limiting,
    input wire logic [load_switch_pkg::NUM_SWITCHES-1:0] i_switch_overtemp,
    input wire logic [2:0] i_pmic_state,
    input wire logic i_seq_low_on,
    input wire logic i_seq_low_off,
    input wire logic i_enable_write,
    input wire logic [load_switch_pkg::NUM_SWITCHES-1:0] i_enable_wdata,
    input wire logic [load_switch_pkg::NUM_SWITCHES-1:0] i_switch_discharge_enable,
    input wire logic [load_switch_pkg::NUM_SWITCHES-1:0] i_switch_shed_on_fail,
    input wire logic [1:0] i_five_volt_limit_select,
    input wire logic [1:0] i_high_voltage_limit_select,
    input wire logic i_shutdown_on_fail_enable,
    input wire logic [load_switch_pkg::NUM_SWITCHES-1:0] i_overcurrent_clear,
    input wire logic [load_switch_pkg::NUM_SWITCHES-1:0] i_fault_clear,
    output logic o_backup_power_good,
    output logic [load_switch_pkg::NUM_SWITCHES-1:0] o_switch_on_bit,
    output logic [load_switch_pkg::NUM_SWITCHES-1:0] o_switch_gate,
    output logic [load_switch_pkg::NUM_SWITCHES-1:0] o_switch_discharge,
    output logic [load_switch_pkg::NUM_SWITCHES-1:0] o_switch_overcurrent_irq,
    output logic [load_switch_pkg::NUM_SWITCHES-1:0] o_switch_fault_irq,
    output logic [1:0] o_five_volt_limit,
    output logic [1:0] o_high_voltage_limit,
    output logic o_start_powerdown,
    output logic o_core_reset,
    output logic o_force_off,
    output logic [load_switch_pkg::NUM_RAILS-1:0] o_rail_discharge,
    output logic o_path_coin_cell
);
    import load_switch_pkg::*;

    logic [NUM_FLAGS-1:0] raw_flags;
    logic [NUM_FLAGS-1:0] meta_flags;
    logic [NUM_FLAGS-1:0] flags;
    logic pfail_prev;
    logic pfail_rise;
    logic core_clear;
    logic [NUM_SWITCHES-1:0] forced_off;
    logic [NUM_SWITCHES-1:0] shed_now;
    logic [NUM_SWITCHES-1:0] next_on;
    logic [UV_CNT_W-1:0] uv_count;
    logic uv_dip;
    logic uv_recovered;
    logic uv_expired;
    logic slow_slew;
    logic powered_up;
    path_t path_sel;
    path_t next_path;

    assign raw_flags = {i_switch_overtemp, i_switch_limiting, i_five_volt_in_low, i_fast_slew,
                        i_main_backup_higher, i_coin_cell_higher, i_bias_below_regulator,
                        i_powerfail_sense_input, i_uv_below_hys, i_uv_below, i_sys_below_min,
                        i_io_buck_good, i_core_buck_good};

    // two-stage synchronizer; only the second stage is read
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            meta_flags <= '0;
            flags <= '0;
        end
        else
        begin
            meta_flags <= raw_flags;
            flags <= meta_flags;
        end
    end

    // collapse of supply or bias acts like a core reset on the enable, gate, interrupt, limit, dip timer and power-down registers
    assign core_clear = flags[FLG_SYS_LOW] | flags[FLG_BIAS_LOW];
    assign pfail_rise = flags[FLG_PFAIL] & ~pfail_prev;
    assign powered_up = (i_pmic_state != PMIC_OFF);

    // backup good is a plain and of both bucks, registered once more after the sync stages
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            o_backup_power_good <= 1'b0;
        else
            o_backup_power_good <= flags[FLG_CORE_GOOD] & flags[FLG_IO_GOOD];
    end

    // backup good feeds nothing else here, so its faults cannot shut anything down
    assign o_rail_discharge = {NUM_RAILS{o_core_reset}};

    // local protection holds the gate off without touching the enable bit
    always_comb
    begin
        forced_off = flags[FLG_OTEMP +: NUM_SWITCHES];
        forced_off[SW_FIVE] = forced_off[SW_FIVE] | flags[FLG_FIVE_IN_LOW];
    end

    // shedding only clears enable bits, so recovery needs a fresh host write, or a sequencer on for the low-voltage switch
    assign shed_now = {NUM_SWITCHES{flags[FLG_PFAIL]}} & i_switch_shed_on_fail;

    // enable register: host write, sequencer on low-voltage switch, then shedding
    always_comb
    begin
        next_on = o_switch_on_bit;
        if (i_enable_write)
            next_on = i_enable_wdata;
        if (i_seq_low_on)
            next_on[SW_LOW] = 1'b1;
        if (i_seq_low_off)
            next_on[SW_LOW] = 1'b0;
        next_on = next_on & ~shed_now;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n || core_clear)
            o_switch_on_bit <= SWITCH_ON_RESET;
        else
            o_switch_on_bit <= next_on;
    end

    // gate and discharge are registered so the pins never glitch between them
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n || core_clear)
        begin
            o_switch_gate <= '0;
            o_switch_discharge <= '0;
        end
        else
        begin
            o_switch_gate <= next_on & ~forced_off;
            o_switch_discharge <= i_switch_discharge_enable & ~(next_on & ~forced_off);
        end
    end

    // sticky interrupts; a new event in the clearing cycle wins
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n || core_clear)
        begin
            o_switch_overcurrent_irq <= '0;
            o_switch_fault_irq <= '0;
        end
        else
        begin
            o_switch_overcurrent_irq <= (o_switch_overcurrent_irq & ~i_overcurrent_clear)
                                        | flags[FLG_LIMIT +: NUM_SWITCHES];
            o_switch_fault_irq <= (o_switch_fault_irq & ~i_fault_clear) | forced_off;
        end
    end

    // current limit selections, latched so the analog trim sees stable codes
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n || core_clear)
        begin
            o_five_volt_limit <= LIMIT_RESET;
            o_high_voltage_limit <= LIMIT_RESET;
        end
        else
        begin
            o_five_volt_limit <= i_five_volt_limit_select;
            o_high_voltage_limit <= i_high_voltage_limit_select;
        end
    end

    // slew class is caught while off, then fixes the recovery level for the on period
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            slow_slew <= 1'b0;
        else if (!powered_up)
            slow_slew <= ~flags[FLG_FAST_SLEW];
    end

    assign uv_dip = flags[FLG_UV_LOW];
    assign uv_recovered = slow_slew ? ~flags[FLG_UV_HYS_LOW] : ~flags[FLG_UV_LOW];
    assign uv_expired = (uv_count == UV_CNT_W'(UV_DIP_LIMIT - 1));

    // dip timer: runs from the dip up to UV_DIP_LIMIT - 1, then holds there and requests power-down each cycle until recovery
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n || core_clear || !powered_up)
            uv_count <= '0;
        else if (uv_recovered)
            uv_count <= '0;
        else if ((uv_dip || uv_count != '0) && !uv_expired)
            uv_count <= uv_count + UV_CNT_W'(1);
    end

    // power-down request; no power-fail state is exposed anywhere else
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n || core_clear)
            o_start_powerdown <= 1'b0;
        else
            o_start_powerdown <= (pfail_rise & i_shutdown_on_fail_enable)
                                 | (uv_expired & ~uv_recovered & powered_up);
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            o_core_reset <= 1'b0;
            o_force_off <= 1'b0;
            pfail_prev <= 1'b0;
        end
        else
        begin
            o_core_reset <= core_clear;
            o_force_off <= flags[FLG_BIAS_LOW];
            pfail_prev <= flags[FLG_PFAIL];
        end
    end

    // backup power path; hysteresis lives in the analog comparators
    always_comb
    begin
        next_path = path_sel;
        case (path_sel)
            PATH_MAIN:
                if (flags[FLG_COIN_HI])
                    next_path = PATH_COIN;
            PATH_COIN:
                if (flags[FLG_MAIN_HI])
                    next_path = PATH_MAIN;
            default:
                next_path = PATH_MAIN;
        endcase
        if (powered_up || flags[FLG_BIAS_LOW])
            next_path = PATH_MAIN;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            path_sel <= PATH_MAIN;
        else
            path_sel <= next_path;
    end

    assign o_path_coin_cell = (path_sel == PATH_COIN);

    // checks
    sequence raw_both_good;
        i_core_buck_good && i_io_buck_good;
    endsequence

    backup_good_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        raw_both_good ##1 raw_both_good ##1 raw_both_good |=> o_backup_power_good)
        else $error("backup good low while both bucks good");

    backup_fault_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !flags[FLG_CORE_GOOD] |=> !o_backup_power_good)
        else $error("backup good high with core buck down");

    core_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        flags[FLG_SYS_LOW] |=> o_core_reset && o_rail_discharge == '1 && o_switch_gate == '0)
        else $error("low supply did not kill rails");

    shed_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        flags[FLG_PFAIL] && i_switch_shed_on_fail[SW_HIGH] |=> !o_switch_on_bit[SW_HIGH])
        else $error("shed switch left enabled");

    shed_stays_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !o_switch_on_bit[SW_FIVE] && !i_enable_write |=> !o_switch_on_bit[SW_FIVE])
        else $error("switch turned on without host write");

    seq_only_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !i_enable_write && !core_clear && !flags[FLG_PFAIL]
        |=> o_switch_on_bit[SW_HIGH:SW_FIVE] == $past(o_switch_on_bit[SW_HIGH:SW_FIVE]))
        else $error("sequencer moved a host-only switch");

    discharge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !next_on[SW_LOW] && i_switch_discharge_enable[SW_LOW] && !core_clear
        |=> o_switch_discharge[SW_LOW] && !o_switch_gate[SW_LOW])
        else $error("disabled switch not discharged");

    otemp_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        flags[FLG_OTEMP] && !core_clear |=> !o_switch_gate[SW_LOW] && o_switch_fault_irq[SW_LOW])
        else $error("overtemp did not force switch off");

    five_uv_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        flags[FLG_FIVE_IN_LOW] && !core_clear
        |=> !o_switch_gate[SW_FIVE] && o_switch_fault_irq[SW_FIVE])
        else $error("low five-volt input left switch on");

    limit_irq_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        flags[FLG_LIMIT + SW_FIVE] && !core_clear |=> o_switch_overcurrent_irq[SW_FIVE])
        else $error("limiting without overcurrent interrupt");

    pfail_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        pfail_rise && !i_shutdown_on_fail_enable && !uv_expired |=> !o_start_powerdown)
        else $error("power-down from trip while disabled");

    path_main_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        powered_up |=> !o_path_coin_cell)
        else $error("coin cell selected while powered up");

    uv_short_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        uv_recovered && !pfail_rise |=> uv_count == '0 && !uv_expired && !o_start_powerdown)
        else $error("dip timer kept running after recovery");
endmodule

// *** tb/analog_front_model.sv ***
`timescale 1ns/1ps
module analog_front_model (
    input wire logic [15:0] i_main_mv,
    input wire logic [15:0] i_coin_mv,
    input wire logic [15:0] i_five_mv,
    input wire logic [15:0] i_sys_mv,
    output logic o_coin_cell_higher,
    output logic o_main_backup_higher,
    output logic o_five_volt_in_low,
    output logic o_sys_below_min
);
    // the 150 mV margin sits in the comparators, so inside the band neither output is high
    assign o_coin_cell_higher = (i_coin_mv > i_main_mv + 16'h0096);
    assign o_main_backup_higher = (i_main_mv > i_coin_mv + 16'h0096);
    // fixed thresholds; no glitch filter, so any dip is seen at once
    assign o_five_volt_in_low = (i_five_mv < 16'h0A8C);
    assign o_sys_below_min = (i_sys_mv < 16'h09C4);
endmodule

// *** tb/load_switch_powerfail_ctrl_test.sv ***
`timescale 1ns/1ps
module load_switch_powerfail_ctrl_test;
    import load_switch_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic core_good = 1'b0, io_good = 1'b0, uv = 1'b0, powerfail_sense_input = 1'b0, bias = 1'b0, slew = 1'b1;
    logic uv_hys = 1'b0;
    logic coin_hi, main_hi, five_low, sys_low;
    logic seq_on = 1'b0, seq_off = 1'b0, wr = 1'b0, sd_en = 1'b0;
    logic [2:0] lim = 3'h0, otemp = 3'h0, wdata = 3'h0, dis_en = 3'h0, shed = 3'h0;
    logic [2:0] oc_clr = 3'h0, f_clr = 3'h0, state = PMIC_OFF;
    logic [1:0] sel5 = 2'h0, selh = 2'h0, lim5, limh;
    logic [15:0] main_mv = 16'h0BB8, coin_mv = 16'h0AF0, five_mv = 16'h1388, sys_mv = 16'h0E10;
    logic bgood, pdown, creset, foff, path;
    logic [2:0] on_bit, gate, dis, oc_irq, f_irq;
    logic [4:0] rail_dis;
    int n_mismatch = 0, total_checks = 0, n_pd = 0, cycles = 0, n0;
    logic [2:0] st [4] = '{PMIC_AWAIT, PMIC_ACTIVE, PMIC_SUSPEND, PMIC_RECOVERY};

    load_switch_powerfail_ctrl #(.UV_DIP_LIMIT(20)) u_load_switch_powerfail_ctrl (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_core_buck_good(core_good),
        .i_io_buck_good(io_good), .i_sys_below_min(sys_low), .i_uv_below(uv),
        .i_uv_below_hys(uv_hys), .i_powerfail_sense_input(powerfail_sense_input), .i_bias_below_regulator(bias),
        .i_coin_cell_higher(coin_hi), .i_main_backup_higher(main_hi), .i_fast_slew(slew),
        .i_five_volt_in_low(five_low), .i_switch_limiting(lim), .i_switch_overtemp(otemp),
        .i_pmic_state(state), .i_seq_low_on(seq_on), .i_seq_low_off(seq_off),
        .i_enable_write(wr), .i_enable_wdata(wdata), .i_switch_discharge_enable(dis_en),
        .i_switch_shed_on_fail(shed), .i_five_volt_limit_select(sel5),
        .i_high_voltage_limit_select(selh), .i_shutdown_on_fail_enable(sd_en),
        .i_overcurrent_clear(oc_clr), .i_fault_clear(f_clr), .o_backup_power_good(bgood),
        .o_switch_on_bit(on_bit), .o_switch_gate(gate), .o_switch_discharge(dis),
        .o_switch_overcurrent_irq(oc_irq), .o_switch_fault_irq(f_irq),
        .o_five_volt_limit(lim5), .o_high_voltage_limit(limh), .o_start_powerdown(pdown),
        .o_core_reset(creset), .o_force_off(foff), .o_rail_discharge(rail_dis),
        .o_path_coin_cell(path));

    analog_front_model u_analog_front_model (
        .i_main_mv(main_mv), .i_coin_mv(coin_mv), .i_five_mv(five_mv), .i_sys_mv(sys_mv),
        .o_coin_cell_higher(coin_hi), .o_main_backup_higher(main_hi),
        .o_five_volt_in_low(five_low), .o_sys_below_min(sys_low));

    initial
    begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // power-fail requests are one-cycle pulses and dip requests hold until recovery, so count them rather than sample them
    always @(posedge i_clk_sys)
    begin
        if (pdown === 1'b1)
            n_pd <= n_pd + 1;
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task tally_and_finish;
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // step past n edges and let their updates settle before looking
    task tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    // host write: strobe held for exactly one taking edge
    task host_write(input logic [2:0] d);
        @(posedge i_clk_sys);
        wr <= 1'b1;
        wdata <= d;
        @(posedge i_clk_sys);
        wr <= 1'b0;
        #1;
    endtask

    task seq_pulse(input logic on, input logic off);
        @(posedge i_clk_sys);
        seq_on <= on;
        seq_off <= off;
        @(posedge i_clk_sys);
        seq_on <= 1'b0;
        seq_off <= 1'b0;
        #1;
    endtask

    task clr_pulse(input logic [2:0] oc, input logic [2:0] f);
        @(posedge i_clk_sys);
        oc_clr <= oc;
        f_clr <= f;
        @(posedge i_clk_sys);
        oc_clr <= 3'h0;
        f_clr <= 3'h0;
        #1;
    endtask

    initial
    begin
        repeat (16) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        tick(1);
        chk(on_bit, 8'h00);
        chk(dis, 8'h00);
        // power-path: off state follows the higher input, powered states force main
        @(posedge i_clk_sys);
        coin_mv <= 16'h0CE4;
        tick(3);
        chk(path, 8'h01);
        @(posedge i_clk_sys);
        coin_mv <= 16'h0C1C;
        tick(3);
        chk(path, 8'h01);
        @(posedge i_clk_sys);
        coin_mv <= 16'h0CE4;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge i_clk_sys);
            state <= PMIC_OFF;
            tick(1);
            chk(path, 8'h01);
            @(posedge i_clk_sys);
            state <= st[k];
            tick(1);
            chk(path, 8'h00);
        end
        // enables, discharge, sequencer control of the low-voltage switch only
        @(posedge i_clk_sys);
        dis_en <= 3'h7;
        host_write(3'h7);
        chk(on_bit, 8'h07);
        chk(gate, 8'h07);
        chk(dis, 8'h00);
        host_write(3'h2);
        chk(dis, 8'h05);
        host_write(3'h0);
        seq_pulse(1'b1, 1'b0);
        chk(on_bit, 8'h01);
        host_write(3'h7);
        seq_pulse(1'b0, 1'b1);
        chk(on_bit, 8'h06);
        seq_pulse(1'b1, 1'b0);
        chk(on_bit, 8'h07);
        // backup good and isolation of backup faults
        @(posedge i_clk_sys);
        n0 = n_pd;
        core_good <= 1'b1;
        io_good <= 1'b1;
        tick(3);
        chk(bgood, 8'h01);
        @(posedge i_clk_sys);
        io_good <= 1'b0;
        tick(3);
        chk(bgood, 8'h00);
        chk(n_pd - n0, 8'h00);
        chk({creset, on_bit}, 8'h07);
        // current limiting keeps the switch on; overtemp and low input force it off
        @(posedge i_clk_sys);
        lim <= 3'h2;
        tick(3);
        chk({oc_irq, gate}, 8'h17);
        @(posedge i_clk_sys);
        lim <= 3'h0;
        otemp <= 3'h4;
        tick(3);
        clr_pulse(3'h7, 3'h0);
        chk({oc_irq, gate}, 8'h03);
        chk(f_irq, 8'h04);
        @(posedge i_clk_sys);
        otemp <= 3'h0;
        five_mv <= 16'h0A28;
        tick(3);
        chk(gate, 8'h05);
        chk(f_irq, 8'h06);
        @(posedge i_clk_sys);
        five_mv <= 16'h1388;
        tick(3);
        clr_pulse(3'h0, 3'h7);
        chk({f_irq, gate}, 8'h07);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge i_clk_sys);
            sel5 <= k[1:0];
            selh <= 2'h3 - k[1:0];
            tick(1);
            chk({lim5, limh}, {4'h0, k[1:0], 2'h3 - k[1:0]});
        end
        // power-fail load shedding, then shutdown when enabled
        @(posedge i_clk_sys);
        n0 = n_pd;
        shed <= 3'h5;
        powerfail_sense_input <= 1'b1;
        tick(3);
        chk(on_bit, 8'h02);
        chk(n_pd - n0, 8'h00);
        host_write(3'h7);
        chk(on_bit, 8'h02);
        @(posedge i_clk_sys);
        powerfail_sense_input <= 1'b0;
        tick(3);
        chk(on_bit, 8'h02);
        host_write(3'h7);
        chk(on_bit, 8'h07);
        @(posedge i_clk_sys);
        sd_en <= 1'b1;
        powerfail_sense_input <= 1'b1;
        tick(5);
        chk(n_pd - n0, 8'h01);
        @(posedge i_clk_sys);
        powerfail_sense_input <= 1'b0;
        // fast slew: a short dip survives though still under the hysteresis level
        n0 = n_pd;
        uv <= 1'b1;
        uv_hys <= 1'b1;
        tick(10);
        @(posedge i_clk_sys);
        uv <= 1'b0;
        tick(30);
        chk(n_pd - n0, 8'h00);
        @(posedge i_clk_sys);
        uv <= 1'b1;
        tick(40);
        chk(n_pd != n0, 8'h01);
        @(posedge i_clk_sys);
        uv <= 1'b0;
        uv_hys <= 1'b0;
        sys_mv <= 16'h0960;
        tick(3);
        chk({creset, on_bit}, 8'h08);
        chk(rail_dis, 8'h1F);
        @(posedge i_clk_sys);
        sys_mv <= 16'h0E10;
        state <= PMIC_OFF;
        tick(3);
        chk(path, 8'h01);
        // slow slew: recovery needs the hysteresis level, so the same dip now expires
        @(posedge i_clk_sys);
        slew <= 1'b0;
        tick(3);
        @(posedge i_clk_sys);
        state <= PMIC_RECOVERY;
        n0 = n_pd;
        uv <= 1'b1;
        uv_hys <= 1'b1;
        tick(10);
        @(posedge i_clk_sys);
        uv <= 1'b0;
        tick(30);
        chk(n_pd != n0, 8'h01);
        @(posedge i_clk_sys);
        uv_hys <= 1'b0;
        state <= PMIC_OFF;
        tick(3);
        chk(path, 8'h01);
        @(posedge i_clk_sys);
        bias <= 1'b1;
        tick(3);
        chk({foff, path}, 8'h02);
        tally_and_finish();
    end
endmodule
